/* design/vlp_port.sv */
/*
 Service port of a virtual channel link control sublayer: three request
 streams merged towards the access sublayer, and one indication stream.
 Assumes request fields stay stable while their VALID is high, and that
 the indication user takes every beat (no back-pressure upward).
*/
// How it works
// - Multiplex units are whole octets, at most 65542, within configured limits.
// - Only one bitstream source per channel; bitstream stays on its own channel.
// - Bitstream beats are delivered as they come; fill is marked by kind.
// - Packet channel id comes from the packet application id field.
// - Reserved application ids are global; only user ids get qualified.
// - User ids are qualified by spacecraft id followed by version bits 01.
// - Channel unit id is spacecraft id followed by channel id.
// - Bitstream loss flag follows the loss flag from below.
// - Encapsulation loss comes from gaps in the packet sequence count.
// - Loss flag presence is fixed by package constants.
// - Encapsulation request carries unit, channel and packet channel id.
// - Encapsulated arrivals delivered with unit id, channel id and loss.
// - Each encapsulation unit is wrapped, multiplexed and sent.
// - Multiplex headers are parsed; encapsulation and bitstream stay opaque.
// - Multiplex units share the named channel with encapsulation packets.
// - Encapsulation units are whole octets, at most 65536, within limits.
module vlp_port
   import vlp_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   input  wire logic [7:0]  SCID,
   input  wire logic [16:0] LEN_MIN,
   input  wire logic [16:0] LEN_MAX,
   input  wire logic [5:0]  BS_VCID,
   input  wire logic [10:0] ENC_PCID,
   input  wire logic        E_VALID,
   input  wire logic [7:0]  E_DATA,
   input  wire logic        E_LAST,
   input  wire logic [16:0] E_LEN,
   input  wire logic [5:0]  E_VCID,
   input  wire logic [10:0] E_PCID,
   output logic             E_READY,
   input  wire logic        M_VALID,
   input  wire logic [7:0]  M_DATA,
   input  wire logic        M_LAST,
   input  wire logic [16:0] M_LEN,
   input  wire logic [5:0]  M_VCID,
   output logic             M_READY,
   input  wire logic        B_VALID,
   input  wire logic [7:0]  B_DATA,
   input  wire logic        B_LAST,
   input  wire logic [5:0]  B_VCID,
   output logic             B_READY,
   output logic             REJECT,
   output logic             D_VALID,
   output logic [7:0]       D_DATA,
   output logic             D_LAST,
   output logic [13:0]      D_VCDU,
   input  wire logic        D_READY,
   input  wire logic        U_VALID,
   input  wire logic [7:0]  U_DATA,
   input  wire logic        U_LAST,
   input  wire logic        U_BITS,
   input  wire logic [13:0] U_VCDU,
   input  wire logic        U_LOSS,
   output logic             I_VALID,
   output logic [7:0]       I_DATA,
   output logic             I_LAST,
   output logic             I_HDR,
   output logic [1:0]       I_KIND,
   output logic [10:0]      I_PCID,
   output logic [13:0]      I_VCDU,
   output logic [9:0]       I_QUAL,
   output logic             I_QVALID,
   output logic             I_LOSS
);
   typedef enum logic [1:0] {S_IDLE, S_HDR, S_DATA, S_DROP} vlp_tx_t;

   function automatic logic len_bad(input logic [16:0] len,
                                    input logic [16:0] lim);
      len_bad = (len == 17'h0_0000) || (len < LEN_MIN) ||
                (len > LEN_MAX) || (len > lim);
   endfunction

   // ---------------------------------------------------------------
   // Request side
   // ---------------------------------------------------------------
   vlp_tx_t     state;
   vlp_tx_t     next_state;
   logic [1:0]  sel_q;
   logic [5:0]  vcid_q;
   logic [10:0] pcid_q;
   logic [15:0] plen_q;
   logic [2:0]  idx;
   logic [13:0] seq;
   logic        sk_valid;
   logic [22:0] sk;
   logic [7:0]  hdr_b;

   wire        any    = E_VALID | M_VALID | B_VALID;
   wire [1:0]  pick   = E_VALID ? K_ENC : (M_VALID ? K_MUX : K_BITS);
   wire        e_bad  = len_bad(E_LEN, E_MAX_LEN) || (E_VCID == BS_VCID);
   wire        m_bad  = len_bad(M_LEN, M_MAX_LEN) || (M_VCID == BS_VCID);
   wire        b_bad  = B_VCID != BS_VCID;
   wire        p_bad  = (pick == K_ENC) ? e_bad : ((pick == K_MUX) ? m_bad : b_bad);
   wire [5:0]  p_vcid = (pick == K_ENC) ? E_VCID : ((pick == K_MUX) ? M_VCID : B_VCID);
   wire        src_v  = (sel_q == K_ENC) ? E_VALID : ((sel_q == K_MUX) ? M_VALID : B_VALID);
   wire        src_r  = (sel_q == K_ENC) ? E_READY : ((sel_q == K_MUX) ? M_READY : B_READY);
   wire        src_l  = (sel_q == K_ENC) ? E_LAST : ((sel_q == K_MUX) ? M_LAST : B_LAST);
   wire [7:0]  src_d  = (sel_q == K_ENC) ? E_DATA : ((sel_q == K_MUX) ? M_DATA : B_DATA);
   wire        acc    = src_v & src_r;
   wire        hpush  = (state == S_HDR) & ~sk_valid;
   wire        push   = hpush | (acc & (state == S_DATA));
   wire        pop    = D_VALID & D_READY;
   wire [22:0] pay    = {(state == S_DATA) & src_l, SCID, vcid_q,
                         (state == S_HDR) ? hdr_b : src_d};
   wire        next_sk = sk_valid ? ~pop : (push & D_VALID & ~pop);
   wire [1:0]  next_sel = (state == S_IDLE) ? pick : sel_q;
   wire        next_rdy = (next_state == S_DROP) |
                          ((next_state == S_DATA) & ~next_sk);

   // Header of the wrapping packet; data stays untouched behind it
   always_comb begin
      unique case (idx)
         3'h0:    hdr_b = {5'h00, pcid_q[10:8]};
         3'h1:    hdr_b = pcid_q[7:0];
         3'h2:    hdr_b = {SEQ_FLAGS, seq[13:8]};
         3'h3:    hdr_b = seq[7:0];
         3'h4:    hdr_b = plen_q[15:8];
         default: hdr_b = plen_q[7:0];
      endcase
   end

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: begin
            if (any) begin
               next_state = p_bad ? S_DROP : ((pick == K_ENC) ? S_HDR : S_DATA);
            end
         end
         S_HDR: begin
            if (hpush && idx == HDR_LAST) begin
               next_state = S_DATA;
            end
         end
         S_DATA, S_DROP: begin
            if (acc && src_l) begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state   <= S_IDLE;
         sel_q   <= K_ENC;
         E_READY <= 1'b0;
         M_READY <= 1'b0;
         B_READY <= 1'b0;
      end else begin
         state   <= next_state;
         sel_q   <= next_sel;
         // Ready looks one cycle ahead so it can come from a flop
         E_READY <= next_rdy & (next_sel == K_ENC);
         M_READY <= next_rdy & (next_sel == K_MUX);
         B_READY <= next_rdy & (next_sel == K_BITS);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         vcid_q <= 6'h00;
         pcid_q <= 11'h000;
         plen_q <= 16'h0000;
         REJECT <= 1'b0;
      end else begin
         REJECT <= (state == S_IDLE) & any & p_bad;
         if (state == S_IDLE && any) begin
            vcid_q <= p_vcid;
            pcid_q <= E_PCID;
            plen_q <= 16'(E_LEN - LEN_ONE);
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         idx <= 3'h0;
         seq <= 14'h0000;
      end else if (hpush) begin
         idx <= (idx == HDR_LAST) ? 3'h0 : 3'(idx + 3'h1);
         if (idx == HDR_LAST) begin
            seq <= 14'(seq + 14'h0001);
         end
      end
   end

   // ---------------------------------------------------------------
   // Two-entry buffer towards the access sublayer
   // ---------------------------------------------------------------
   // Encapsulation and multiplex units share this path.
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         D_VALID  <= 1'b0;
         {D_LAST, D_VCDU, D_DATA} <= 23'h00_0000;
         sk_valid <= 1'b0;
         sk       <= 23'h00_0000;
      end else begin
         if (!D_VALID || pop) begin
            D_VALID <= sk_valid | push;
            {D_LAST, D_VCDU, D_DATA} <= sk_valid ? sk : pay;
         end
         sk_valid <= next_sk;
         if (push && D_VALID && !pop) begin
            sk <= pay;
         end
      end
   end

   // ---------------------------------------------------------------
   // Indication side
   // ---------------------------------------------------------------
   logic [2:0]  ridx;
   logic [2:0]  apid_hi;
   logic [5:0]  seq_hi;
   logic [13:0] seq_exp;
   logic        seen;
   logic        enc_unit;
   logic        lossp;

   wire        u_pkt   = U_VALID & ~U_BITS;
   wire [10:0] u_apid  = {apid_hi, U_DATA};
   wire        u_enc   = u_apid == ENC_PCID;
   wire [13:0] seq_now = {seq_hi, U_DATA};
   wire        at_seq  = u_pkt & (ridx == SEQ_IDX) & enc_unit;
   wire        gap     = at_seq & seen & (seq_now != seq_exp);
   wire [1:0]  u_kind  = (u_apid == APID_FILL) ? K_FILL : (u_enc ? K_ENC : K_MUX);

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ridx     <= 3'h0;
         apid_hi  <= 3'h0;
         seq_hi   <= 6'h00;
         seq_exp  <= 14'h0000;
         seen     <= 1'b0;
         enc_unit <= 1'b0;
         lossp    <= 1'b0;
      end else if (U_VALID) begin
         ridx <= U_LAST ? 3'h0 : ((ridx == HDR_LEN) ? ridx : 3'(ridx + 3'h1));
         if (u_pkt && ridx == 3'h0) begin
            apid_hi <= U_DATA[2:0];
         end
         if (u_pkt && ridx == 3'h1) begin
            enc_unit <= u_enc;
         end
         if (u_pkt && ridx == 3'h2) begin
            seq_hi <= U_DATA[5:0];
         end
         if (at_seq) begin
            seen    <= 1'b1;
            seq_exp <= 14'(seq_now + 14'h0001);
         end
         // A gap on the closing beat is reported there, so nothing carries over
         lossp <= (gap | lossp) & ~U_LAST;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         I_VALID  <= 1'b0;
         I_DATA   <= 8'h00;
         I_LAST   <= 1'b0;
         I_HDR    <= 1'b0;
         I_KIND   <= K_MUX;
         I_PCID   <= 11'h000;
         I_VCDU   <= 14'h0000;
         I_QUAL   <= 10'h000;
         I_QVALID <= 1'b0;
         I_LOSS   <= 1'b0;
      end else begin
         I_VALID <= U_VALID;
         if (U_VALID) begin
            I_DATA <= U_DATA;
            I_LAST <= U_LAST;
            I_HDR  <= u_pkt & (ridx < HDR_LEN);
            I_VCDU <= U_VCDU;
            I_QUAL <= {U_VCDU[13:6], QUAL_VER};
            // Bitstream beats pass through as they come.
            I_LOSS <= U_BITS ? (U_LOSS & LOSS_BS_EN)
                             : ((gap | lossp) & U_LAST & enc_unit & LOSS_ENC_EN);
            if (U_BITS) begin
               I_KIND   <= K_BITS;
               I_QVALID <= 1'b0;
            end else if (ridx == 3'h1) begin
               I_KIND   <= u_kind;
               I_PCID   <= u_apid;
               I_QVALID <= u_apid != APID_FILL;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_enc_start;
      state == S_IDLE && any && !p_bad && pick == K_ENC;
   endsequence
   sequence s_hdr_done;
      hpush && idx == HDR_LAST;
   endsequence
   sequence s_gap_close;
      gap ##[1:9] (U_VALID && U_LAST && !U_BITS);
   endsequence

   a_enc_wraps: assert property (s_enc_start |=> state == S_HDR)
      else $error("encapsulation unit not wrapped");
   a_hdr_then_data: assert property (s_hdr_done |=> state == S_DATA && seq == $past(seq) + 14'h0001)
      else $error("header end mishandled");
   a_drop_nofwd: assert property (state == S_DROP |=> !$rose(D_VALID))
      else $error("rejected unit forwarded");
   a_reject_pulse: assert property (state == S_IDLE && any && p_bad |=> REJECT && state == S_DROP)
      else $error("bad length not rejected");
   a_bits_vc: assert property (state == S_DATA && sel_q == K_BITS |-> vcid_q == BS_VCID)
      else $error("bitstream on foreign channel");
   a_buf_hold: assert property (D_VALID && !D_READY |=> D_VALID && $stable(D_DATA))
      else $error("buffer dropped a word");
   a_ready_room: assert property ((E_READY || M_READY || B_READY) && state == S_DATA |-> !sk_valid)
      else $error("ready without room");
   a_bs_loss: assert property (U_VALID && U_BITS && U_LOSS |=> I_VALID && I_LOSS)
      else $error("bitstream loss missed");
   a_enc_gap: assert property (s_gap_close |=> I_LOSS)
      else $error("sequence gap not reported");
   a_qual_ver: assert property (I_VALID |-> I_QUAL == {$past(U_VCDU[13:6]), QUAL_VER})
      else $error("qualifier malformed");
endmodule

/* inc/vlp_pkg.sv */
/*
 Constants of the link control service port.
 Assumes one 50 MHz clock and octet-wide streams on every side.
*/
package vlp_pkg;
   // ---------------------------------------------------------------
   // Unit lengths in octets
   // ---------------------------------------------------------------
   localparam logic [16:0] E_MAX_LEN = 17'h1_0000;
   localparam logic [16:0] M_MAX_LEN = 17'h1_0006;
   localparam logic [16:0] LEN_ONE   = 17'h0_0001;
   // ---------------------------------------------------------------
   // Packet header
   // ---------------------------------------------------------------
   localparam logic [2:0]  HDR_LAST  = 3'h5;
   localparam logic [2:0]  HDR_LEN   = 3'h6;
   localparam logic [2:0]  SEQ_IDX   = 3'h3;
   localparam logic [1:0]  SEQ_FLAGS = 2'h3;
   localparam logic [10:0] APID_FILL = 11'h7ff;
   localparam logic [1:0]  QUAL_VER  = 2'h1;
   // ---------------------------------------------------------------
   // Optional loss flags, fixed at design time
   // ---------------------------------------------------------------
   localparam logic        LOSS_BS_EN  = 1'h1;
   localparam logic        LOSS_ENC_EN = 1'h1;
   // ---------------------------------------------------------------
   // Unit kinds, also the source select code
   // ---------------------------------------------------------------
   localparam logic [1:0]  K_ENC  = 2'h0;
   localparam logic [1:0]  K_MUX  = 2'h1;
   localparam logic [1:0]  K_BITS = 2'h2;
   localparam logic [1:0]  K_FILL = 2'h3;
endpackage

/* test/vlp_lower_model.sv */
/*
 Behavioural access sublayer below the service port: stalls and collects
 the down stream, and drives indication beats upward on request.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
module vlp_lower_model
   import vlp_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        D_VALID,
   input  wire logic [7:0]  D_DATA,
   input  wire logic [13:0] D_VCDU,
   output logic             D_READY,
   output logic             U_VALID,
   output logic [7:0]       U_DATA,
   output logic             U_LAST,
   output logic             U_BITS,
   output logic [13:0]      U_VCDU,
   output logic             U_LOSS
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  q[$];
   logic [13:0] vcdu_seen = 14'h0000;
   logic [1:0]  cnt = 2'h0;
   initial begin
      D_READY = 1'b0;
      {U_VALID, U_LAST, U_BITS, U_LOSS} = 4'h0;
      U_DATA = 8'h00;
      U_VCDU = 14'h0000;
   end
   // ---------------------------------------------------------------
   // Down side: one stall in four tests the two-entry buffer
   // ---------------------------------------------------------------
   always @(posedge CLK_SYS) begin
      cnt <= cnt + 2'h1;
      if (D_VALID === 1'b1 && D_READY === 1'b1) begin
         q.push_back(D_DATA);
         vcdu_seen = D_VCDU;
      end
      #1 D_READY = (cnt != 2'h3);
   end
   // ---------------------------------------------------------------
   // Up side: loss flag given on every gap it is told of
   // ---------------------------------------------------------------
   task up(input logic [7:0] d, input logic l, b, s, input logic [13:0] v);
      U_VALID = 1'b1;
      U_DATA = d;
      U_LAST = l;
      U_BITS = b;
      U_VCDU = v;
      U_LOSS = s;
      @(posedge CLK_SYS);
      #1;
   endtask
   task rest();
      // Released data line inverts so a stale octet is never mistaken
      U_VALID = 1'b0;
      U_DATA = ~U_DATA;
   endtask
endmodule

/* test/vlp_port_bench.sv */
/*
 Self-checking bench of the service port: send, refuse and receive.
 Assumes the lower model stands on the down and up sides.
*/
module vlp_port_bench;
   import vlp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0]  SC = 8'h5a;
   localparam logic [5:0]  BV = 6'h07;
   localparam logic [10:0] EP = 11'h123;
   logic        CLK_SYS = 1'b0;
   logic        RSTN = 1'b0;
   logic        vld = 1'b0;
   logic        lst = 1'b0;
   logic [7:0]  dat = 8'h00;
   logic [16:0] len = 17'h0_0000;
   logic [5:0]  vc = 6'h00;
   logic [1:0]  knd = 2'h0;
   logic [10:0] pc = 11'h000;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          n_rej = 0;
   int          n_dn = 0;
   int          last_at = 0;
   int          n_hdr = 0;
   logic [31:0] ind[7];
   wire         E_READY, M_READY, B_READY, REJECT, D_VALID, D_LAST, D_READY;
   wire  [7:0]  D_DATA, U_DATA, I_DATA;
   wire  [13:0] D_VCDU, U_VCDU, I_VCDU;
   wire         U_VALID, U_LAST, U_BITS, U_LOSS, I_VALID, I_LAST, I_HDR, I_QVALID, I_LOSS;
   wire  [1:0]  I_KIND;
   wire  [10:0] I_PCID;
   wire  [9:0]  I_QUAL;
   wire         rdy = knd == K_ENC ? E_READY : knd == K_MUX ? M_READY : B_READY;
   always #10 CLK_SYS = ~CLK_SYS;
   vlp_port dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .SCID(SC), .LEN_MIN(LEN_ONE),
      .LEN_MAX(17'h0_0040), .BS_VCID(BV), .ENC_PCID(EP), .E_VALID(vld && knd == K_ENC),
      .E_DATA(dat), .E_LAST(lst), .E_LEN(len), .E_VCID(vc), .E_PCID(pc), .E_READY(E_READY),
      .M_VALID(vld && knd == K_MUX), .M_DATA(dat), .M_LAST(lst), .M_LEN(len), .M_VCID(vc),
      .M_READY(M_READY), .B_VALID(vld && knd == K_BITS), .B_DATA(dat), .B_LAST(lst),
      .B_VCID(vc), .B_READY(B_READY), .REJECT(REJECT), .D_VALID(D_VALID), .D_DATA(D_DATA),
      .D_LAST(D_LAST), .D_VCDU(D_VCDU), .D_READY(D_READY), .U_VALID(U_VALID),
      .U_DATA(U_DATA), .U_LAST(U_LAST), .U_BITS(U_BITS), .U_VCDU(U_VCDU), .U_LOSS(U_LOSS),
      .I_VALID(I_VALID), .I_DATA(I_DATA), .I_LAST(I_LAST), .I_HDR(I_HDR), .I_KIND(I_KIND),
      .I_PCID(I_PCID), .I_VCDU(I_VCDU), .I_QUAL(I_QUAL), .I_QVALID(I_QVALID),
      .I_LOSS(I_LOSS));
   vlp_lower_model pm (.CLK_SYS(CLK_SYS), .D_VALID(D_VALID), .D_DATA(D_DATA),
      .D_VCDU(D_VCDU), .D_READY(D_READY), .U_VALID(U_VALID), .U_DATA(U_DATA),
      .U_LAST(U_LAST), .U_BITS(U_BITS), .U_VCDU(U_VCDU), .U_LOSS(U_LOSS));
   always @(posedge CLK_SYS) begin
      if (REJECT === 1'b1) n_rej++;
      if (D_VALID === 1'b1 && D_READY === 1'b1) begin
         n_dn++;
         if (D_LAST === 1'b1) last_at = n_dn;
      end
      if (I_VALID === 1'b1 && I_HDR === 1'b1) n_hdr++;
      if (I_VALID === 1'b1 && I_LAST === 1'b1)
         ind = '{I_KIND, I_PCID, I_VCDU, I_QUAL, I_QVALID, I_LOSS, I_DATA};
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task chk(input logic [31:0] e, g);
      cmp_count++;
      if (e !== g) begin
         n_errors++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask
   task send(input logic [1:0] k, input logic [5:0] v, input int n, input logic [16:0] l);
      int w;
      pm.q.delete();
      n_dn = 0;
      last_at = 0;
      knd = k;
      vc = v;
      len = l;
      for (int i = 0; i < n; i++) begin
         dat = 8'h10 + i[7:0];
         lst = (i == n - 1);
         vld = 1'b1;
         w = 0;
         do begin
            @(posedge CLK_SYS);
            w++;
         end while (rdy !== 1'b1 && w < 300);
         if (w >= 300) chk(32'h1, 32'h0);
         #1;
      end
      vld = 1'b0;
      lst = 1'b0;
      idle(30);
   endtask
   task end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_mux();
      send(K_MUX, 6'h03, 3, 17'h0_0003);
      chk(3, pm.q.size());
      chk(3, last_at);
      for (int i = 0; i < 3; i++) chk(8'h10 + i, pm.q[i]);
      chk({SC, 6'h03}, pm.vcdu_seen);
      $display("test mux done");
   endtask
   task t_enc();
      pc = 11'h2a5;
      send(K_ENC, 6'h04, 2, 17'h0_0002);
      chk(8, pm.q.size());
      chk(8, last_at);
      chk({5'h00, pc[10:8]}, pm.q[0]);
      chk(pc[7:0], pm.q[1]);
      chk(2'h3, pm.q[2][7:6]);
      chk(16'h0001, {pm.q[4], pm.q[5]});
      chk(16'h1011, {pm.q[6], pm.q[7]});
      chk({SC, 6'h04}, pm.vcdu_seen);
      $display("test enc done");
   endtask
   task t_rej();
      logic [24:0] bad[4] = '{{K_ENC, 6'h04, 17'h0_0000}, {K_MUX, BV, 17'h0_0001},
                               {K_BITS, 6'h03, 17'h0_0001}, {K_MUX, 6'h03, 17'h0_0041}};
      for (int i = 0; i < 4; i++) begin
         n_rej = 0;
         send(bad[i][24:23], bad[i][22:17], 1, bad[i][16:0]);
         chk(1, n_rej);
         chk(0, pm.q.size());
      end
      $display("test refuse done");
   endtask
   task t_bits();
      send(K_BITS, BV, 2, 17'h0_0002);
      chk(16'h1011, {pm.q[0], pm.q[1]});
      chk(2, last_at);
      chk({SC, BV}, pm.vcdu_seen);
      $display("test bits done");
   endtask
   task pkt(input logic [10:0] a, input logic [7:0] sq);
      n_hdr = 0;
      pm.up({5'h00, a[10:8]}, 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(a[7:0], 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(8'hc0, 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(sq, 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(8'h00, 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(8'h00, 1'b0, 1'b0, 1'b0, {SC, 6'h04});
      pm.up(8'h77, 1'b1, 1'b0, 1'b0, {SC, 6'h04});
      pm.rest();
      idle(3);
      chk(6, n_hdr);
   endtask
   task t_up();
      logic [7:0] s[3] = '{8'h00, 8'h01, 8'h03};
      for (int p = 0; p < 3; p++) begin
         pkt(EP, s[p]);
         if (p > 0) chk(p == 2, ind[5]);
      end
      chk({K_ENC, EP, SC, 6'h04}, {ind[0][1:0], ind[1][10:0], ind[2][13:0]});
      chk(8'h77, ind[6]);
      chk({SC, QUAL_VER, 1'b1}, {ind[3][9:0], ind[4][0]});
      pkt(APID_FILL, 8'h05);
      chk({K_FILL, 1'b0, 1'b0}, {ind[0][1:0], ind[4][0], ind[5][0]});
      pkt(11'h045, 8'h09);
      chk({K_MUX, 11'h045, 1'b1, 1'b0}, {ind[0][1:0], ind[1][10:0], ind[4][0], ind[5][0]});
      n_hdr = 0;
      pm.up(8'h3c, 1'b1, 1'b1, 1'b1, {SC, BV});
      pm.rest();
      idle(3);
      chk({K_BITS, 1'b0, 1'b1}, {ind[0][1:0], ind[4][0], ind[5][0]});
      chk(8'h3c, ind[6]);
      chk(0, n_hdr);
      $display("test receive done");
   endtask
   initial begin
      #100us;
      n_errors++;
      end_sim();
   end
   initial begin
      idle(20);
      RSTN = 1'b1;
      idle(2);
      t_mux();
      t_enc();
      t_rej();
      t_bits();
      t_up();
      end_sim();
   end
endmodule
